// [hw/fmc_carrier_gen.sv]
// phase-continuous square carrier synthesised from the 1 us reference tick
`timescale 1ns/1ps
`include "fmc_defs.svh"
module fmc_carrier_gen (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic ref_tick, // 1 us enable pulse
  input wire logic run, // carrier on
  input wire logic orig_band, // 1: low band, 0: high band
  input wire logic mark, // bit being sent
  output logic sq_out // square wave at carrier frequency
);
  localparam logic [23:0] STEP_OM = 24'(`FMC_STEP(`FMC_ORIG_MARK_HZ));
  localparam logic [23:0] STEP_OS = 24'(`FMC_STEP(`FMC_ORIG_SPACE_HZ));
  localparam logic [23:0] STEP_AM = 24'(`FMC_STEP(`FMC_ANS_MARK_HZ));
  localparam logic [23:0] STEP_AS = 24'(`FMC_STEP(`FMC_ANS_SPACE_HZ));

  logic [23:0] acc_reg;
  logic [23:0] acc_next;
  logic [23:0] step;

  // ****************************************************************
  // step selection and accumulation
  // ****************************************************************
  // accumulator is never reloaded on a bit change: the new step takes
  // over at the next tick, so no phase jump and under 1 us to settle
  always_comb begin
    unique case ({orig_band, mark})
      2'b11: step = STEP_OM;
      2'b10: step = STEP_OS;
      2'b01: step = STEP_AM;
      2'b00: step = STEP_AS;
    endcase
    acc_next = acc_reg;
    if (!run) begin
      acc_next = 24'h000000;
    end else if (ref_tick) begin
      acc_next = acc_reg + step;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 24'h000000;
    end else begin
      acc_reg <= acc_next;
    end
  end

  assign sq_out = acc_reg[23];

  chk_carrier_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> !sq_out) else $error("carrier square active while stopped");
endmodule : fmc_carrier_gen

// [hw/fmc_defs.svh]
// constants for the modem control block: offsets, fields, resets, timing
`ifndef FMC_DEFS_SVH
`define FMC_DEFS_SVH

// ****************************************************************
// clocking
// ****************************************************************
`define FMC_PCLK_HZ 40000000
`define FMC_REF_HZ 1000000
`define FMC_REF_DIV (`FMC_PCLK_HZ / `FMC_REF_HZ)

// ****************************************************************
// supervision times, in their own units, and counts of 1 us ticks
// ****************************************************************
`define FMC_BRK_TIME_MS 150
`define FMC_SHORT_TIME_MS 300
`define FMC_LONG_TIME_MS 1500
`define FMC_BRK_TICKS (`FMC_BRK_TIME_MS * (`FMC_REF_HZ / 1000))
`define FMC_SHORT_TICKS (`FMC_SHORT_TIME_MS * (`FMC_REF_HZ / 1000))
`define FMC_LONG_TICKS (`FMC_LONG_TIME_MS * (`FMC_REF_HZ / 1000))

// ****************************************************************
// carrier synthesis: 24-bit phase step per 1 us reference tick
// ****************************************************************
`define FMC_ACC_W 24
`define FMC_ORIG_MARK_HZ 1270
`define FMC_ORIG_SPACE_HZ 1070
`define FMC_ANS_MARK_HZ 2225
`define FMC_ANS_SPACE_HZ 2025
`define FMC_STEP(f) (((f) * 64'h0000_0000_0100_0000) / `FMC_REF_HZ)

// ****************************************************************
// register map
// ****************************************************************
`define FMC_CTRL_OFS 12'h000
`define FMC_STAT_OFS 12'h004
`define FMC_CTRL_HANGUP_BIT 0
`define FMC_CTRL_BRKREL_BIT 1
`define FMC_STAT_SEIZE_BIT 0
`define FMC_STAT_ORIG_BIT 1
`define FMC_STAT_EST_BIT 2
`define FMC_STAT_BRK_BIT 3
`define FMC_STAT_CTSN_BIT 4
`define FMC_STAT_SELFTEST_BIT 5
`define FMC_STAT_STATE_LSB 6
`define FMC_PRDATA_RST 32'h0000_0000

`endif

// [hw/fmc_pkg.sv]
// types shared by the modem control block
package fmc_pkg;
  typedef enum logic [1:0] {
    FMC_IDLE = 2'b00,
    FMC_ONLINE = 2'b01,
    FMC_HANGUP = 2'b11
  } fmc_state_e;
endpackage : fmc_pkg

// [hw/fmc_top.sv]
// control and signalling logic of the low-speed fsk modem, with apb access
//
// Notes on behaviour
// - short-space strap low: hang up after 0.3 s
// - long-space strap low: hang up after 1.5 s
// - self test retunes demodulator to transmit band
// - self test keeps established channel state
// - mode low answering, high originating
// - mode output inverts during self test
// - seize line on request and terminal ready
// - release line output after call completes
// - clear-to-send low only once data unclamped
// - receive data: mark high, space low
// - 150 ms space latches receive break high
// - receive break high until clear-to-send
// - test output squares at transmit frequency
// - originate carrier 1270 mark, 1070 space
// - answer carrier 2225 mark, 2025 space
// - new frequency within 1 us, phase-continuous
// - reset holds line released and idle
// - ring selects answer, off-hook selects originate
`timescale 1ns/1ps
`include "fmc_defs.svh"
module fmc_top #(
  parameter int unsigned BRK_TICKS = `FMC_BRK_TICKS, // break space, 1 us ticks
  parameter int unsigned SHORT_TICKS = `FMC_SHORT_TICKS, // short hang-up space
  parameter int unsigned LONG_TICKS = `FMC_LONG_TICKS // long hang-up space
) (
  input wire logic pclk, // 40 MHz system clock
  input wire logic presetn, // async reset, active low
  input wire logic [11:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic short_space_hangup_strap, // low enables 0.3 s hang-up
  input wire logic long_space_hangup_strap, // low enables 1.5 s hang-up
  input wire logic factory_test_clock, // high: reference tick every clock
  input wire logic loopback_selftest_n, // low: self test
  input wire logic offhook_request_n, // low: originate request
  input wire logic ring_detect_n, // low: ring qualified
  input wire logic dtr_n, // low: terminal ready
  input wire logic chan_est, // high: handshake has established channel
  input wire logic tx_data_in, // terminal data, mark high
  input wire logic demod_bit_in, // demodulator output, mark high
  output logic line_seize_out, // high: coupler off hook
  output logic mode_out, // high originate, low answer, inverted in test
  output logic cts_n, // low: clear to send
  output logic rx_data_out, // received data, mark high
  output logic rx_break_out, // high: break latched or not yet clear
  output logic carrier_square_test_out // square at transmit frequency
);
  localparam int unsigned CNT_W = 21;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [5:0] REF_LAST = 6'(`FMC_REF_DIV - 1);

  initial begin
    if (`FMC_REF_DIV < 2 || `FMC_REF_DIV > 64) begin
      $error("reference divider out of range");
    end
    if (LONG_TICKS >= (1 << CNT_W) || SHORT_TICKS == 0 || BRK_TICKS == 0) begin
      $error("space timer counts out of range");
    end
  end

  // ****************************************************************
  // 1 us reference enable
  // ****************************************************************
  logic [5:0] div_reg;
  logic [5:0] div_next;
  logic ref_tick;

  always_comb begin
    div_next = (div_reg == REF_LAST) ? 6'h00 : div_reg + 6'h01;
    // shortened timing for production test only
    ref_tick = (div_reg == REF_LAST) | factory_test_clock;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 6'h00;
    end else begin
      div_reg <= div_next;
    end
  end

  // ****************************************************************
  // apb slave: zero wait states, read data captured in the setup cycle, writes act in the access cycle
  // ****************************************************************
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic setup_ph;
  logic hit_ctrl;
  logic hit_stat;
  logic wr_ctrl;
  logic hangup_cmd;
  logic brk_release;
  logic [31:0] status_word;

  always_comb begin
    setup_ph = psel & ~penable;
    hit_ctrl = (paddr == `FMC_CTRL_OFS);
    hit_stat = (paddr == `FMC_STAT_OFS);
    wr_ctrl = psel & penable & pwrite & hit_ctrl;
    hangup_cmd = wr_ctrl & pwdata[`FMC_CTRL_HANGUP_BIT];
    brk_release = wr_ctrl & pwdata[`FMC_CTRL_BRKREL_BIT];
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup_ph) begin
      prdata_next = (!pwrite && hit_stat) ? status_word : 32'h0000_0000;
      pslverr_next = ~(hit_ctrl | hit_stat);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= `FMC_PRDATA_RST;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg & psel & penable;

  // ****************************************************************
  // call supervision
  // ****************************************************************
  fmc_pkg::fmc_state_e state_reg;
  fmc_pkg::fmc_state_e state_next;
  logic orig_reg;
  logic orig_next;
  logic est_reg;
  logic est_next;
  logic brk_reg;
  logic brk_next;
  logic [CNT_W-1:0] space_cnt_reg;
  logic [CNT_W-1:0] space_cnt_next;
  logic seize_reg;
  logic mode_reg;
  logic cts_n_reg;
  logic rxd_reg;
  logic rxbrk_reg;
  logic seize_next;
  logic mode_next;
  logic cts_n_next;
  logic rxd_next;
  logic rxbrk_next;
  logic online;
  logic space_now;
  logic call_req;
  logic space_disc;
  logic selftest;
  logic tx_bit;

  always_comb begin
    online = (state_reg == fmc_pkg::FMC_ONLINE);
    selftest = ~loopback_selftest_n;
    call_req = ~offhook_request_n | ~ring_detect_n;
    space_now = online & ~demod_bit_in;
    // timer restarts whenever the received line leaves space
    space_cnt_next = space_cnt_reg;
    if (!space_now) begin
      space_cnt_next = '0;
    end else if (ref_tick && space_cnt_reg != CNT_MAX) begin
      space_cnt_next = space_cnt_reg + 1'b1;
    end
    // both straps low is a board error; either one then hangs up
    space_disc = (~short_space_hangup_strap & (space_cnt_reg >= CNT_W'(SHORT_TICKS)))
               | (~long_space_hangup_strap & (space_cnt_reg >= CNT_W'(LONG_TICKS)));
    state_next = state_reg;
    orig_next = orig_reg;
    est_next = est_reg;
    unique case (state_reg)
      fmc_pkg::FMC_IDLE: begin
        est_next = 1'b0;
        if (call_req && !dtr_n) begin
          state_next = fmc_pkg::FMC_ONLINE;
          orig_next = ring_detect_n;
        end
      end
      fmc_pkg::FMC_ONLINE: begin
        est_next = est_reg | chan_est;
        if (space_disc || hangup_cmd || dtr_n) begin
          state_next = fmc_pkg::FMC_HANGUP;
          est_next = 1'b0;
        end
      end
      fmc_pkg::FMC_HANGUP: begin
        // wait for requests to drop so the line is not seized again at once
        est_next = 1'b0;
        if (!call_req) begin
          state_next = fmc_pkg::FMC_IDLE;
        end
      end
      default: begin
        state_next = fmc_pkg::FMC_IDLE;
        est_next = 1'b0;
      end
    endcase
    // a break that lands with the release write still latches
    brk_next = (brk_reg & ~brk_release & online)
             | (space_now & (space_cnt_reg >= CNT_W'(BRK_TICKS)));
    tx_bit = cts_n_reg | tx_data_in;
    seize_next = (state_next == fmc_pkg::FMC_ONLINE);
    mode_next = orig_next ^ selftest;
    cts_n_next = ~est_next;
    rxd_next = ~est_next | demod_bit_in;
    rxbrk_next = brk_next | ~est_next;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= fmc_pkg::FMC_IDLE;
      orig_reg <= 1'b0;
      est_reg <= 1'b0;
      brk_reg <= 1'b0;
      space_cnt_reg <= '0;
      seize_reg <= 1'b0;
      mode_reg <= 1'b0;
      cts_n_reg <= 1'b1;
      rxd_reg <= 1'b1;
      rxbrk_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      orig_reg <= orig_next;
      est_reg <= est_next;
      brk_reg <= brk_next;
      space_cnt_reg <= space_cnt_next;
      seize_reg <= seize_next;
      mode_reg <= mode_next;
      cts_n_reg <= cts_n_next;
      rxd_reg <= rxd_next;
      rxbrk_reg <= rxbrk_next;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`FMC_STAT_SEIZE_BIT] = seize_reg;
    status_word[`FMC_STAT_ORIG_BIT] = orig_reg;
    status_word[`FMC_STAT_EST_BIT] = est_reg;
    status_word[`FMC_STAT_BRK_BIT] = brk_reg;
    status_word[`FMC_STAT_CTSN_BIT] = cts_n_reg;
    status_word[`FMC_STAT_SELFTEST_BIT] = selftest;
    status_word[`FMC_STAT_STATE_LSB +: 2] = state_reg;
  end

  assign line_seize_out = seize_reg;
  assign mode_out = mode_reg;
  assign cts_n = cts_n_reg;
  assign rx_data_out = rxd_reg;
  assign rx_break_out = rxbrk_reg;

  // ****************************************************************
  // transmit carrier; low band when originating, independent of test
  // ****************************************************************
  fmc_carrier_gen u_carrier (
    .pclk(pclk),
    .presetn(presetn),
    .ref_tick(ref_tick),
    .run(seize_reg),
    .orig_band(orig_reg),
    .mark(tx_bit),
    .sq_out(carrier_square_test_out)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_seize_on_req: assert property (
    state_reg == fmc_pkg::FMC_IDLE && call_req && !dtr_n |=> line_seize_out
  ) else $error("line not seized on request");
  chk_release_on_hangup: assert property (
    online && hangup_cmd |=> !line_seize_out ##1 !line_seize_out
  ) else $error("line held after hang-up");
  chk_mode_select: assert property (
    state_reg == fmc_pkg::FMC_IDLE && !ring_detect_n && !dtr_n |=> !orig_reg
  ) else $error("ring did not select answer");
  chk_mode_invert: assert property (
    state_reg != fmc_pkg::FMC_IDLE && $stable(loopback_selftest_n)
    |-> mode_out == (orig_reg == loopback_selftest_n)
  ) else $error("mode output wrong");
  chk_est_kept_test: assert property (
    online && est_reg && $changed(loopback_selftest_n) && !dtr_n && !hangup_cmd
    && !space_disc |=> est_reg
  ) else $error("self test dropped channel");
  chk_cts_clamp: assert property (
    cts_n |-> tx_bit
  ) else $error("data passed while not clear");
  chk_brk_before_cts: assert property (
    cts_n |-> rx_break_out
  ) else $error("break low before clear");
  chk_brk_latch: assert property (
    space_now && space_cnt_reg >= CNT_W'(BRK_TICKS) |=> brk_reg && rx_break_out
  ) else $error("break not latched");
  chk_short_disc: assert property (
    online && !short_space_hangup_strap && space_cnt_reg >= CNT_W'(SHORT_TICKS)
    |=> state_reg == fmc_pkg::FMC_HANGUP ##1 !line_seize_out
  ) else $error("short space did not hang up");
  chk_timer_restart: assert property (
    online && demod_bit_in |=> space_cnt_reg == '0
  ) else $error("space timer not restarted");
  chk_rx_clamp: assert property (
    !est_reg |-> rx_data_out
  ) else $error("receive data not clamped to mark");

  cov_answer_call: cover property (
    state_reg == fmc_pkg::FMC_IDLE && !ring_detect_n ##1 online ##[1:100] !cts_n
  );
  cov_break: cover property ($rose(brk_reg));
  cov_selftest: cover property (est_reg && $rose(loopback_selftest_n));
  cov_space_disc: cover property (online && space_disc);
endmodule : fmc_top

// [sim/fmc_remote_model.sv]
// far-side model: data coupler and remote modem feeding the demodulator path
`timescale 1ns/1ps
module fmc_remote_model (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic line_seize_out, // coupler off hook
  input wire logic slow, // 1: long handshake
  input wire logic send_space, // 1: remote sends continuous space
  output logic demod_bit_in, // demodulated bit, mark high
  output logic chan_est // handshake done
);
  // ****************************************************************
  // handshake stand-in and receive line
  // ****************************************************************
  logic [7:0] wait_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 8'h00;
      chan_est <= 1'b0;
      demod_bit_in <= 1'b1;
    end else if (!line_seize_out) begin
      // no carrier on hook: demod output wanders, never a steady value
      wait_reg <= 8'h00;
      chan_est <= 1'b0;
      demod_bit_in <= ~demod_bit_in;
    end else begin
      if (wait_reg < (slow ? 8'h32 : 8'h02)) begin
        wait_reg <= wait_reg + 8'h01;
      end else begin
        chan_est <= 1'b1;
      end
      demod_bit_in <= ~send_space;
    end
  end
endmodule : fmc_remote_model

// [sim/fmc_top_tb_top.sv]
// self-checking testbench of the modem control block
`timescale 1ns/1ps
`include "fmc_defs.svh"
module fmc_top_tb_top;
  // ****************************************************************
  // shortened supervision counts, in 1 us ticks
  // ****************************************************************
  localparam int BRK = 5;
  localparam int SHRT = 10;
  localparam int LNG = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ss_n, ls_n, tclk, stest_n, oh_n, ring_n, dtr_n, est, txd, dmod, slow, spc;
  logic seize, mode, cts_n, rxd, rxb, sq;
  int mismatches = 0;
  int num_checks = 0;

  fmc_top #(.BRK_TICKS(BRK), .SHORT_TICKS(SHRT), .LONG_TICKS(LNG)) u_fmc_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .short_space_hangup_strap(ss_n), .long_space_hangup_strap(ls_n),
    .factory_test_clock(tclk), .loopback_selftest_n(stest_n), .offhook_request_n(oh_n),
    .ring_detect_n(ring_n), .dtr_n(dtr_n), .chan_est(est), .tx_data_in(txd),
    .demod_bit_in(dmod), .line_seize_out(seize), .mode_out(mode), .cts_n(cts_n),
    .rx_data_out(rxd), .rx_break_out(rxb), .carrier_square_test_out(sq));

  fmc_remote_model u_fmc_remote_model (.pclk(pclk), .presetn(presetn),
    .line_seize_out(seize), .slow(slow), .send_space(spc), .demod_bit_in(dmod),
    .chan_est(est));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk; // 1 us reference is divided from this
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] q, output logic e);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    chk("pready", 1, pready);
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge, so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask : apb

  task automatic edge_wait(output int c);
    logic v;
    v = sq;
    c = 0;
    while (sq === v && c < 2000) begin
      @(posedge pclk);
      c++;
    end
  endtask : edge_wait

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_refused();
    ring_n <= 1'b0;
    oh_n <= 1'b0;
    cyc(5);
    chk("seize without ready", 0, seize);
    ring_n <= 1'b1;
    oh_n <= 1'b1;
    cyc(2);
  endtask : t_refused

  task automatic t_call(input logic ring, input logic lb, input logic sl);
    int n = 0;
    stest_n <= ~lb;
    slow <= sl;
    dtr_n <= 1'b0;
    if (ring) begin
      ring_n <= 1'b0;
    end else begin
      oh_n <= 1'b0;
    end
    cyc(4);
    chk("seize", 1, seize);
    chk("mode", {~ring ^ lb}, mode);
    if (sl) begin
      chk("cts_n before handshake", 1, cts_n);
      chk("break before clear", 1, rxb);
    end
    while (cts_n !== 1'b0 && n < 200) begin
      cyc(1);
      n++;
    end
    cyc(2);
    chk("cts_n", 0, cts_n);
    chk("break after clear", 0, rxb);
    chk("rx data mark", 1, rxd);
  endtask : t_call

  task automatic t_release();
    dtr_n <= 1'b1;
    cyc(3);
    chk("seize after release", 0, seize);
    ring_n <= 1'b1;
    oh_n <= 1'b1;
    cyc(3);
  endtask : t_release

  task automatic t_status();
    logic [31:0] e;
    e = (32'h1 << `FMC_STAT_SEIZE_BIT) | (32'h1 << `FMC_STAT_EST_BIT);
    e = e | (32'(fmc_pkg::FMC_ONLINE) << `FMC_STAT_STATE_LSB);
    apb(1'b0, `FMC_STAT_OFS, 32'h0, rd, err);
    chk("status", e, rd);
    chk("status error", 0, err);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
  endtask : t_status

  task automatic t_break();
    spc <= 1'b1;
    cyc((BRK - 1) * 40 - 2);
    chk("break early", 0, rxb);
    chk("rx data space", 0, rxd);
    cyc(48);
    chk("break latched", 1, rxb);
    spc <= 1'b0;
    cyc(3);
    chk("break held", 1, rxb);
    apb(1'b1, `FMC_CTRL_OFS, 32'h2, rd, err);
    cyc(3);
    chk("break released", 0, rxb);
    chk("seize with straps high", 1, seize);
  endtask : t_break

  task automatic t_space_hup(input int n);
    spc <= 1'b1;
    cyc((n - 1) * 40 - 2);
    spc <= 1'b0;
    cyc(3);
    spc <= 1'b1;
    cyc((n - 1) * 40 - 2);
    chk("seize after restart", 1, seize);
    cyc(48);
    chk("seize after space", 0, seize);
    spc <= 1'b0;
  endtask : t_space_hup

  task automatic t_carrier(input logic orig);
    int c;
    int f;
    int e;
    // test clock makes every pclk a tick, so a half period is short
    tclk <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      txd <= b[0];
      if (orig) begin
        f = b ? `FMC_ORIG_MARK_HZ : `FMC_ORIG_SPACE_HZ;
      end else begin
        f = b ? `FMC_ANS_MARK_HZ : `FMC_ANS_SPACE_HZ;
      end
      e = `FMC_REF_HZ / (2 * f);
      repeat (3) edge_wait(c);
      if (c >= e - 2 && c <= e + 2) begin
        c = e;
      end
      chk("carrier half period", e, c);
    end
    tclk <= 1'b0; // back to normal operation
    txd <= 1'b1;
  endtask : t_carrier

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, tclk, slow, spc} = '0;
    paddr = '0;
    pwdata = '0;
    {ss_n, ls_n, stest_n, oh_n, ring_n, dtr_n, txd} = '1;
    presetn = 1'b0;
    cyc(6);
    presetn <= 1'b1;
    cyc(2);
    chk("seize at reset", 0, seize);
    chk("break at reset", 1, rxb);
    chk("cts_n at reset", 1, cts_n);
    chk("carrier on hook", 0, sq);
    t_refused();
    t_call(1'b1, 1'b0, 1'b1);
    t_status();
    t_break();
    t_carrier(1'b0);
    apb(1'b1, `FMC_CTRL_OFS, 32'h1, rd, err);
    cyc(3);
    chk("seize after hangup", 0, seize);
    t_release();
    t_call(1'b0, 1'b1, 1'b0);
    stest_n <= 1'b1;
    cyc(3);
    chk("mode after self test", 1, mode);
    chk("cts_n kept", 0, cts_n);
    t_carrier(1'b1);
    ss_n <= 1'b0;
    t_space_hup(SHRT);
    t_release();
    ss_n <= 1'b1; // never both straps low
    t_call(1'b0, 1'b0, 1'b0);
    ls_n <= 1'b0;
    t_space_hup(LNG);
    t_release();
    conclude();
  end

  initial begin
    #1000000;
    mismatches++;
    conclude();
  end
endmodule : fmc_top_tb_top
